/* dswp_pkg.sv */
/*
  dswp_pkg: shared constants and carrier types for the serial write port
  of the voltage-output converter.
  assumes: compiled before every other file of the block.
*/
package dswp_pkg;

  // ---------------------------------------------------------------------
  // frame and code widths
  // ---------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CODE_BITS  = 16;
  localparam int unsigned CTRL_BITS  = FRAME_BITS - CODE_BITS;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned FIFO_DEPTH = 16;

  // ---------------------------------------------------------------------
  // reset values and code conversion
  // ---------------------------------------------------------------------
  localparam logic [CODE_BITS-1:0] MIDSCALE  = 16'h8000;
  localparam logic [CODE_BITS-1:0] SIGN_FLIP = 16'h8000;

  // ---------------------------------------------------------------------
  // timing: clock rate and host serial clock limit
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned SCLK_MAX_MHZ = 30;
  // least system cycles per serial period at the maximum rate
  localparam int unsigned SCLK_MIN_CYC = CLK_MHZ / SCLK_MAX_MHZ;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_BITS-1:0] ctrl;
    logic [CODE_BITS-1:0] data;
  } dswp_word_s;

  typedef struct packed {
    logic                 pd_unused;
    logic [CODE_BITS-1:0] code;
  } dswp_out_s;

endpackage : dswp_pkg

/* dswp_fifo.sv */
/*
  dswp_fifo: synchronous FIFO with valid/ready on both sides.
  assumes: one clock, synchronous active-low reset.
*/
`timescale 1ns/10ps
module dswp_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // handshake and pointer update
  always_comb begin
    in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    out_valid_o = (cnt_ff != '0);
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    nxt_wp      = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp      = pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt     = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    out_data_o  = mem[rp_ff];
  end

  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_ff] <= in_data_i;
    end
    if (!rst_b_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : dswp_fifo

/* dswp_top.sv */
/*
  dswp_top: three-wire serial write port of the 16-bit converter.
  assumes: frame select, serial clock and data come from pins on another
  clock; the core clock (250 MHz) oversamples them.
*/
// Functional notes
// - frame select is active low and level sensitive; shifting only while low.
// - one data bit is shifted in on each of the first 24 serial clock falling edges of a frame; later edges are ignored.
// - after the 24th falling edge the converter code is updated.
// - frame select rising before the 24th edge aborts and drops the write.
// - after reset the code stays midscale until a full frame is accepted.
// - the received value is two's complement when forming the code.
`timescale 1ns/10ps
module dswp_top #(
  parameter int unsigned FRAME_BITS = dswp_pkg::FRAME_BITS
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           sel_b_i,
  input  wire logic                           sclk_i,
  input  wire logic                           sdin_i,
  output logic      [dswp_pkg::CODE_BITS-1:0] dac_code_o,
  output logic      [dswp_pkg::CTRL_BITS-1:0] dac_ctrl_o,
  output logic                                update_o,
  output logic                                abort_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} dswp_st_e;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] sel_sync_ff, sclk_sync_ff, sdin_sync_ff;
  logic       sclk_prev_ff, sel_prev_ff;
  logic       sclk_fall, sel_rise;

  // two-flop sync then edge history
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_sync_ff  <= 2'h3;
      sclk_sync_ff <= 2'h0;
      sdin_sync_ff <= 2'h0;
      sclk_prev_ff <= 1'b0;
      sel_prev_ff  <= 1'b1;
    end else begin
      sel_sync_ff  <= {sel_sync_ff[0], sel_b_i};
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
      sdin_sync_ff <= {sdin_sync_ff[0], sdin_i};
      sclk_prev_ff <= sclk_sync_ff[1];
      sel_prev_ff  <= sel_sync_ff[1];
    end
  end

  assign sclk_fall = sclk_prev_ff & ~sclk_sync_ff[1];
  assign sel_rise  = ~sel_prev_ff & sel_sync_ff[1];

  // ---------------------------------------------------------------------
  // frame state machine and shift register
  // ---------------------------------------------------------------------
  dswp_st_e                   st_ff, nxt_st;
  logic [FRAME_BITS-1:0]      sr_ff, nxt_sr;
  logic [dswp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                       push, fifo_rdy, abort_ff, nxt_abort;

  // frame sequencing
  always_comb begin
    nxt_st    = st_ff;
    nxt_sr    = sr_ff;
    nxt_cnt   = cnt_ff;
    push      = 1'b0;
    nxt_abort = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (!sel_sync_ff[1]) begin
          nxt_st  = ST_SHIFT;
          nxt_cnt = '0;
        end
      end
      ST_SHIFT: begin
        if (sel_sync_ff[1]) begin
          nxt_st    = ST_IDLE;
          nxt_abort = 1'b1;
        end else if (sclk_fall) begin
          nxt_sr  = {sr_ff[FRAME_BITS-2:0], sdin_sync_ff[1]};
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == dswp_pkg::CNT_W'(FRAME_BITS - 1)) begin
            push   = fifo_rdy;
            nxt_st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (sel_sync_ff[1]) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff    <= ST_IDLE;
      sr_ff    <= '0;
      cnt_ff   <= '0;
      abort_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      sr_ff    <= nxt_sr;
      cnt_ff   <= nxt_cnt;
      abort_ff <= nxt_abort;
    end
  end

  // ---------------------------------------------------------------------
  // word buffer between frame capture and converter latch
  // ---------------------------------------------------------------------
  dswp_pkg::dswp_word_s fifo_out;
  logic                 fifo_vld;

  dswp_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (dswp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   ({sr_ff[FRAME_BITS-2:0], sdin_sync_ff[1]}),
    .in_valid_i  (push),
    .in_ready_o  (fifo_rdy),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_vld),
    .out_ready_i (1'b1)
  );

  // ---------------------------------------------------------------------
  // converter code latch
  // ---------------------------------------------------------------------
  dswp_pkg::dswp_out_s            out_ff, nxt_out;
  logic [dswp_pkg::CTRL_BITS-1:0] ctrl_ff, nxt_ctrl;
  logic                           upd_ff, nxt_upd;

  // two's complement to offset binary, midscale after reset
  always_comb begin
    nxt_out  = out_ff;
    nxt_ctrl = ctrl_ff;
    nxt_upd  = fifo_vld;
    if (fifo_vld) begin
      nxt_out.code = fifo_out.data ^ dswp_pkg::SIGN_FLIP;
      nxt_ctrl     = fifo_out.ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_ff  <= '{pd_unused: 1'b0, code: dswp_pkg::MIDSCALE};
      ctrl_ff <= '0;
      upd_ff  <= 1'b0;
    end else begin
      out_ff  <= nxt_out;
      ctrl_ff <= nxt_ctrl;
      upd_ff  <= nxt_upd;
    end
  end

  assign dac_code_o = out_ff.code;
  assign dac_ctrl_o = ctrl_ff;
  assign update_o   = upd_ff;
  assign abort_o    = abort_ff;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_shift_gated;
    @(posedge clk_i) disable iff (!rst_b_i)
      sel_sync_ff[1] |=> (st_ff != ST_SHIFT);
  endproperty
  a_shift_gated: assert property (p_shift_gated)
    else $error("shifting while frame select high");

  property p_bit_count;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_ff == ST_SHIFT && !sel_sync_ff[1] && sclk_fall)
      |=> cnt_ff == $past(cnt_ff) + 1'b1;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit count did not advance on falling edge");

  property p_update_after_full;
    @(posedge clk_i) disable iff (!rst_b_i)
      push |-> ##2 update_o;
  endproperty
  a_update_after_full: assert property (p_update_after_full)
    else $error("no update after full frame");

  property p_abort_no_update;
    @(posedge clk_i) disable iff (!rst_b_i)
      abort_o |-> !fifo_vld && $stable(dac_code_o);
  endproperty
  a_abort_no_update: assert property (p_abort_no_update)
    else $error("aborted frame changed the code");

  property p_code_stable;
    @(posedge clk_i) disable iff (!rst_b_i)
      !$past(fifo_vld) |-> $stable(dac_code_o);
  endproperty
  a_code_stable: assert property (p_code_stable)
    else $error("code changed without accepted frame");

  property p_twos;
    @(posedge clk_i) disable iff (!rst_b_i)
      fifo_vld |=> dac_code_o == ($past(fifo_out.data) ^ dswp_pkg::SIGN_FLIP);
  endproperty
  a_twos: assert property (p_twos)
    else $error("code not converted from two's complement");

  property p_done_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_ff == ST_DONE && !sel_sync_ff[1]) |=> st_ff == ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("left done state without select going high");

  property p_no_push_done;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_ff == ST_DONE) |-> !push ##1 $stable(sr_ff);
  endproperty
  a_no_push_done: assert property (p_no_push_done)
    else $error("word pushed after frame complete");

  c_update: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    update_o);
  c_abort: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    abort_o);
  c_rise: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_rise && st_ff == ST_DONE);

endmodule : dswp_top

/* dswp_host.sv */
/*
  dswp_host: behavioural host that writes frames into the serial port.
  assumes: clk_i is the 250 MHz core clock; pins change on its edges.
*/
`timescale 1ns/10ps
module dswp_host #(
  parameter int HALF = 20
) (
  input  wire logic clk_i,
  output logic      sel_b_o,
  output logic      sclk_o,
  output logic      sdin_o
);
  // ---------------------------------------------------------------
  // idle pins: select high, serial clock parked high
  // ---------------------------------------------------------------
  initial begin
    sel_b_o = 1'b1;
    sclk_o  = 1'b1;
    sdin_o  = 1'b0;
  end

  // wait some core cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold

  // n falling edges msb first; select stays high when idle_sel
  task automatic send(input logic [23:0] w, input int n,
                      input bit idle_sel);
    int i;
    sel_b_o <= idle_sel;
    hold(HALF);
    for (i = 0; i < n; i++) begin
      sdin_o <= w[23 - (i % 24)];
      hold(HALF);                  // 160 ns serial period
      sclk_o <= 1'b0;
      hold(HALF);
      sclk_o <= 1'b1;
    end
    hold(HALF);
    sel_b_o <= 1'b1;
    sdin_o  <= ~sdin_o;            // released line shows no stale bit
    hold(HALF);
  endtask : send
endmodule : dswp_host

/* tb_top.sv */
/*
  tb_top: table-driven bench for the serial write port.
  assumes: dswp_host drives the pins; core clock is 250 MHz.
*/
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic [23:0] w;
    int          n;
    bit          hi;
    logic [15:0] exp_c;
    logic [7:0]  exp_t;
    bit          upd;
    bit          abt;
  } dswp_row_s;

  logic                           clk_i;
  logic                           rst_b_i;
  logic                           sel_b;
  logic                           sclk;
  logic                           sdin;
  logic                           update_o;
  logic                           abort_o;
  logic [dswp_pkg::CODE_BITS-1:0] dac_code_o;
  logic [dswp_pkg::CODE_BITS-1:0] exp_code;
  logic [dswp_pkg::CTRL_BITS-1:0] dac_ctrl_o;
  logic [dswp_pkg::CTRL_BITS-1:0] exp_ctrl;
  int                             errors;
  int                             check_count;
  int                             upd_n;
  int                             abt_n;
  int                             e_upd;
  int                             e_abt;
  int                             k;
  dswp_row_s                      rows [8];

  // ---------------------------------------------------------------
  // design, host model, clock and pulse counters
  // ---------------------------------------------------------------
  dswp_top u_dut (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .sel_b_i    (sel_b),
    .sclk_i     (sclk),
    .sdin_i     (sdin),
    .dac_code_o (dac_code_o),
    .dac_ctrl_o (dac_ctrl_o),
    .update_o   (update_o),
    .abort_o    (abort_o)
  );

  dswp_host u_host (
    .clk_i   (clk_i),
    .sel_b_o (sel_b),
    .sclk_o  (sclk),
    .sdin_o  (sdin)
  );

  // core clock, 4 ns
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // count one-cycle pulses
  always @(posedge clk_i) begin
    if (update_o === 1'b1) upd_n++;
    if (abort_o === 1'b1) abt_n++;
  end

  // ---------------------------------------------------------------
  // compare and verdict
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic compare_all();
    check("code", 32'(dac_code_o), 32'(exp_code));
    check("ctrl", 32'(dac_ctrl_o), 32'(exp_ctrl));
    check("updates", upd_n, e_upd);
    check("aborts", abt_n, e_abt);
  endtask : compare_all

  task automatic conclude();
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // bound on the whole run
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence: table loop, then reset in mid-run
  // ---------------------------------------------------------------
  initial begin
    rst_b_i     = 1'b0;
    errors      = 0;
    check_count = 0;
    upd_n       = 0;
    abt_n       = 0;
    e_upd       = 0;
    e_abt       = 0;
    exp_code    = dswp_pkg::MIDSCALE;
    exp_ctrl    = 8'h00;
    // word, edges, select held high, expected code, ctrl, update, abort
    rows = '{
      '{24'hc3ffff, 23, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b1},
      '{24'h127fff, 24, 1'b0, 16'hffff, 8'h12, 1'b1, 1'b0},
      '{24'hab8000, 24, 1'b0, 16'h0000, 8'hab, 1'b1, 1'b0},
      '{24'h5a1234, 10, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b1},
      '{24'h000000, 24, 1'b0, 16'h8000, 8'h00, 1'b1, 1'b0},
      '{24'h3ca5a5, 26, 1'b0, 16'h25a5, 8'h3c, 1'b1, 1'b0},
      '{24'he71111, 24, 1'b1, 16'h0000, 8'h00, 1'b0, 1'b0},
      '{24'h018001, 24, 1'b0, 16'h0001, 8'h01, 1'b1, 1'b0}
    };
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    compare_all();
    for (k = 0; k < 8; k++) begin
      u_host.send(rows[k].w, rows[k].n, rows[k].hi);
      if (rows[k].upd) begin
        exp_code = rows[k].exp_c;
        exp_ctrl = rows[k].exp_t;
      end
      e_upd += rows[k].upd;
      e_abt += rows[k].abt;
      compare_all();
    end
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    exp_code = dswp_pkg::MIDSCALE;
    exp_ctrl = 8'h00;
    compare_all();
    conclude();
  end
endmodule : tb_top
